// file: src/srw_pkg.sv
// package for the system reset and watchdog coordinator
// assumes a single 50 MHz system clock and classic wishbone register access
// Summary of operation
// - shared reset line driven low by either party resets the whole system
// - master reset low asserts processor and chip-select latch reset at once
// - inverted supervisor reset resets serial controllers and usb host immediately
// - arm-bit latch is reset by a delayed copy of supervisor reset or by a processor write of zero
// - processor starts system reset by setting arm bit and stopping strobes
// - watchdog resets about one second after last strobe; arm drives shared line
// - delayed reset clears arm bit, releasing the shared reset line
// - supply monitor below trip level also asserts supervisor reset
// - power good low only while both supplies lie inside their windows
// - processor switches healthy indicator through a port output bit
// - lamp test low forces healthy indicator on
// - lamp test low forces power-good indicator on
package srw_pkg;
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          WDOG_TIMEOUT_MS = 1000;
  localparam int          WDOG_CYCLES     = CLK_HZ / 1000 * WDOG_TIMEOUT_MS;
  localparam int          DELAY_CYCLES    = 16;
  localparam int          SUP_HOLD_CYCLES = 8;
  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_EN     = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_CLR    = 8'h10;
  localparam logic [7:0]  ADDR_WDOG_CNT   = 8'h14;
  // ctrl fields
  localparam int          CTRL_ARM_BIT    = 0;
  localparam int          CTRL_HEALTHY    = 1;
  localparam int          CTRL_STROBE     = 2;
  // irq events
  localparam int          EV_WDOG         = 0;
  localparam int          EV_EXT_RESET    = 1;
  localparam int          EV_PWR_FAIL     = 2;
  localparam int          EV_LOW_SUPPLY   = 3;
  localparam int          NUM_EV          = 4;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  typedef enum logic [1:0] {SUP_IDLE, SUP_HOLD} srw_sup_t;
endpackage

// file: src/srw_delay_line.sv
// delay line producing the delayed supervisor reset
// assumes the supervisor reset is synchronous to CLK_SYS
`timescale 1ns/1ps
module srw_delay_line
  import srw_pkg::*;
#(
  parameter int DEPTH = DELAY_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // data
  input  wire logic din,
  output logic      dout
);
  logic [DEPTH-1:0] pipe_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pipe_ff <= '0;
    end else if (ce) begin
      pipe_ff <= {pipe_ff[DEPTH-2:0], din};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout <= 1'b0;
    end else if (ce) begin
      dout <= pipe_ff[DEPTH-1];
    end
  end
endmodule // srw_delay_line

// file: src/srw_ctrl.sv
// system reset and watchdog coordinator top
// assumes inputs synchronous to CLK_SYS; shared reset pin resolved outside
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module srw_ctrl
  import srw_pkg::*;
#(
  parameter int WDOG_LIMIT = WDOG_CYCLES
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic        CE,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // shared system reset line
  input  wire logic        SHARED_SYSTEM_RESET_N_I,
  output logic             SHARED_SYSTEM_RESET_N_O,
  output logic             SHARED_SYSTEM_RESET_N_OE_N,
  input  wire logic        MASTER_RESET_IN_N,
  // supervisor resets
  output logic             CPU_RESET_N,
  output logic             CS_LATCH_RESET_N,
  output logic             PERIPH_RESET,
  // power monitor
  input  wire logic        SUPPLY_LOW,
  input  wire logic        SUPPLY5_IN_WINDOW,
  input  wire logic        SUPPLY33_IN_WINDOW,
  output logic             POWER_GOOD_N,
  output logic             POWER_GOOD_LED,
  // indicators
  input  wire logic        LAMP_TEST_N,
  output logic             CPU_HEALTHY_LED,
  // interrupt
  output logic             IRQ
);
  logic [31:0]        ctrl_ff;
  logic [31:0]        wdog_cnt_ff;
  logic [NUM_EV-1:0]  irq_stat_ff;
  logic [NUM_EV-1:0]  irq_en_ff;
  logic               wdog_fire_ff;
  logic               ext_low_ff;
  logic               pwr_bad_ff;
  logic               low_ff;
  logic               ack_ff;
  logic               delayed_rst;
  srw_sup_t           sup_state_ff;
  logic [3:0]         sup_hold_ff;

  // bus decode
  wire bus_req   = WB_CYC_I & WB_STB_I & ~ack_ff;
  wire bus_wr    = bus_req & WB_WE_I;
  wire wr_ctrl   = bus_wr & (WB_ADR_I == ADDR_CTRL) & WB_SEL_I[0];
  wire wr_en     = bus_wr & (WB_ADR_I == ADDR_IRQ_EN) & WB_SEL_I[0];
  wire wr_clr    = bus_wr & (WB_ADR_I == ADDR_IRQ_CLR) & WB_SEL_I[0];
  wire strobe    = wr_ctrl & WB_DAT_I[CTRL_STROBE];

  // supervisor reset causes
  wire ext_low   = ~SHARED_SYSTEM_RESET_N_I | ~MASTER_RESET_IN_N;
  wire sup_cause = ext_low | wdog_fire_ff | SUPPLY_LOW;
  wire sup_rst   = sup_cause | (sup_state_ff == SUP_HOLD);
  wire pwr_bad   = ~(SUPPLY5_IN_WINDOW & SUPPLY33_IN_WINDOW);
  wire [NUM_EV-1:0] events = {SUPPLY_LOW & ~low_ff, pwr_bad & ~pwr_bad_ff,
                              ext_low & ~ext_low_ff, wdog_fire_ff};
  wire wdog_hit  = wdog_cnt_ff >= 32'(WDOG_LIMIT - 1);

  wire [31:0] rd_mux =
      (WB_ADR_I == ADDR_CTRL)     ? ctrl_ff :
      (WB_ADR_I == ADDR_STATUS)   ? {28'h000_0000, SUPPLY_LOW, pwr_bad, ext_low,
                                     sup_rst} :
      (WB_ADR_I == ADDR_IRQ_STAT) ? {28'h000_0000, irq_stat_ff} :
      (WB_ADR_I == ADDR_IRQ_EN)   ? {28'h000_0000, irq_en_ff} :
      (WB_ADR_I == ADDR_WDOG_CNT) ? wdog_cnt_ff :
      32'h0000_0000;

  srw_delay_line #(
    .DEPTH (DELAY_CYCLES)
  ) u_delay (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .ce   (CE),
    .din  (sup_rst),
    .dout (delayed_rst)
  );

  // wishbone ack and read data
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ack_ff   <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else if (CE) begin
      ack_ff   <= bus_req;
      WB_DAT_O <= bus_req ? rd_mux : 32'h0000_0000;
    end
  end
  assign WB_ACK_O = ack_ff;

  // control register; arm bit cleared by delayed reset or by a bus write of zero
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl_ff <= CTRL_RESET;
    end else if (CE) begin
      if (wr_ctrl) begin
        ctrl_ff[CTRL_ARM_BIT] <= WB_DAT_I[CTRL_ARM_BIT];
        ctrl_ff[CTRL_HEALTHY] <= WB_DAT_I[CTRL_HEALTHY];
      end
      if (delayed_rst) begin
        ctrl_ff[CTRL_ARM_BIT] <= 1'b0;
      end
    end
  end

  // watchdog counter
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      wdog_cnt_ff  <= 32'h0000_0000;
      wdog_fire_ff <= 1'b0;
    end else if (CE) begin
      if (strobe || sup_cause && !wdog_fire_ff) begin
        wdog_cnt_ff  <= 32'h0000_0000;
        wdog_fire_ff <= 1'b0;
      end else if (wdog_hit) begin
        wdog_fire_ff <= 1'b1;
        wdog_cnt_ff  <= 32'h0000_0000;
      end else if (wdog_fire_ff) begin
        wdog_fire_ff <= 1'b0;
      end else begin
        wdog_cnt_ff  <= wdog_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // supervisor hold after cause removed
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      sup_state_ff <= SUP_IDLE;
      sup_hold_ff  <= 4'h0;
    end else if (CE) begin
      case (sup_state_ff)
        SUP_IDLE: begin
          if (sup_cause) begin
            sup_state_ff <= SUP_HOLD;
            sup_hold_ff  <= 4'(SUP_HOLD_CYCLES);
          end
        end
        SUP_HOLD: begin
          if (sup_cause) begin
            sup_hold_ff <= 4'(SUP_HOLD_CYCLES);
          end else if (sup_hold_ff == 4'h0) begin
            sup_state_ff <= SUP_IDLE;
          end else begin
            sup_hold_ff <= sup_hold_ff - 4'h1;
          end
        end
        default: sup_state_ff <= SUP_IDLE;
      endcase
    end
  end

  // reset and indicator outputs
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      CPU_RESET_N                <= 1'b0;
      CS_LATCH_RESET_N           <= 1'b0;
      PERIPH_RESET               <= 1'b1;
      SHARED_SYSTEM_RESET_N_O    <= 1'b0;
      SHARED_SYSTEM_RESET_N_OE_N <= 1'b1;
      POWER_GOOD_N               <= 1'b1;
      POWER_GOOD_LED             <= 1'b0;
      CPU_HEALTHY_LED            <= 1'b0;
    end else if (CE) begin
      CPU_RESET_N                <= ~sup_rst;
      CS_LATCH_RESET_N           <= ~sup_rst;
      PERIPH_RESET               <= sup_rst;
      SHARED_SYSTEM_RESET_N_O    <= 1'b0;
      SHARED_SYSTEM_RESET_N_OE_N <= ~(sup_rst & ctrl_ff[CTRL_ARM_BIT]);
      POWER_GOOD_N               <= pwr_bad;
      POWER_GOOD_LED             <= ~pwr_bad | ~LAMP_TEST_N;
      CPU_HEALTHY_LED            <= ctrl_ff[CTRL_HEALTHY] | ~LAMP_TEST_N;
    end
  end

  // interrupt status, enable, clear; set wins over clear
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      irq_stat_ff <= '0;
      irq_en_ff   <= '0;
      ext_low_ff  <= 1'b0;
      pwr_bad_ff  <= 1'b0;
      low_ff      <= 1'b0;
      IRQ         <= 1'b0;
    end else if (CE) begin
      ext_low_ff  <= ext_low;
      pwr_bad_ff  <= pwr_bad;
      low_ff      <= SUPPLY_LOW;
      irq_stat_ff <= (irq_stat_ff & ~(wr_clr ? WB_DAT_I[NUM_EV-1:0] : '0)) | events;
      if (wr_en) begin
        irq_en_ff <= WB_DAT_I[NUM_EV-1:0];
      end
      IRQ <= |(irq_stat_ff & irq_en_ff);
    end
  end
endmodule // srw_ctrl

// file: test/srw_lcu_model.sv
// local control unit model: master reset drive and shared line pull-up
// assumes oe_n low while the coordinator pulls the shared line low
`timescale 1ns/1ps
module srw_lcu_model (
  // clock and request
  input  wire logic clk,
  input  wire logic press,
  // shared line
  input  wire logic oe_n,
  output logic      master_reset_in_n,
  output logic      shared_n
);
  initial master_reset_in_n = 1'b1;
  always @(posedge clk) master_reset_in_n <= !press;
  // pull-up: low while either party pulls
  assign shared_n = master_reset_in_n & oe_n;
endmodule // srw_lcu_model

// file: test/srw_ctrl_sva.sv
// checker for the reset and watchdog coordinator ports
// assumes one clock domain and the async reset RESET
`timescale 1ns/1ps
module srw_ctrl_sva (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // inputs
  input wire logic MASTER_RESET_IN_N,
  input wire logic SUPPLY_LOW,
  input wire logic SUPPLY5_IN_WINDOW,
  input wire logic SUPPLY33_IN_WINDOW,
  input wire logic LAMP_TEST_N,
  // outputs
  input wire logic CPU_RESET_N,
  input wire logic CS_LATCH_RESET_N,
  input wire logic PERIPH_RESET,
  input wire logic POWER_GOOD_N,
  input wire logic POWER_GOOD_LED,
  input wire logic CPU_HEALTHY_LED,
  input wire logic SHARED_SYSTEM_RESET_N_OE_N
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  chk_master_reset: assert property (!MASTER_RESET_IN_N |=> !CPU_RESET_N && !CS_LATCH_RESET_N)
    else $error("master reset not passed on");
  chk_periph_follow: assert property (PERIPH_RESET == !CPU_RESET_N)
    else $error("peripheral reset differs");
  chk_supply_trip: assert property (SUPPLY_LOW |=> !CPU_RESET_N)
    else $error("low supply gave no reset");
  chk_pgood_window: assert property (1 |=> POWER_GOOD_N ==
    !($past(SUPPLY5_IN_WINDOW) && $past(SUPPLY33_IN_WINDOW)))
    else $error("power good wrong");
  chk_lamp_pgood: assert property (!LAMP_TEST_N |=> POWER_GOOD_LED)
    else $error("lamp test left power led dark");
  chk_lamp_healthy: assert property (!LAMP_TEST_N |=> CPU_HEALTHY_LED)
    else $error("lamp test left healthy led dark");
  chk_drive_in_reset: assert property (!SHARED_SYSTEM_RESET_N_OE_N |-> !CPU_RESET_N)
    else $error("shared line driven outside reset");
  chk_drive_release: assert property ($fell(SHARED_SYSTEM_RESET_N_OE_N) |->
    ##[1:40] SHARED_SYSTEM_RESET_N_OE_N)
    else $error("shared line never released");
endmodule // srw_ctrl_sva
bind srw_ctrl srw_ctrl_sva srw_ctrl_sva_i (.*);

// file: test/srw_ctrl_tb.sv
// self-checking bench for the reset and watchdog coordinator
// assumes a shortened watchdog limit and the local control unit model
`timescale 1ns/1ps
module srw_ctrl_tb;
  import srw_pkg::*;
  localparam int LIM = 1000;
  logic clk_sys, reset, cyc, stb, we, press, low, s5, s33, lamp_n;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, r, rexp;
  wire logic [31:0] dat_o;
  wire logic ack, oe_n, mres_n, sh_n, cpu_n, cs_n, per, pg_n, pg_led, hl, irq, sho;
  logic [31:0] expq[$];
  int miscompares, cmp_count, k, i;
  `define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
  `define WAITF(c) begin for (k = 0; k < 3000 && !(c); k++) @(negedge clk_sys); \
    if (!(c)) begin miscompares++; finish_test(); end end
  srw_ctrl #(.WDOG_LIMIT(LIM)) srw_ctrl_i (.CLK_SYS(clk_sys), .RESET(reset), .CE(1'b1),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SHARED_SYSTEM_RESET_N_I(sh_n),
    .SHARED_SYSTEM_RESET_N_O(sho), .SHARED_SYSTEM_RESET_N_OE_N(oe_n), .MASTER_RESET_IN_N(mres_n),
    .CPU_RESET_N(cpu_n), .CS_LATCH_RESET_N(cs_n), .PERIPH_RESET(per), .SUPPLY_LOW(low),
    .SUPPLY5_IN_WINDOW(s5), .SUPPLY33_IN_WINDOW(s33), .POWER_GOOD_N(pg_n),
    .POWER_GOOD_LED(pg_led), .LAMP_TEST_N(lamp_n), .CPU_HEALTHY_LED(hl), .IRQ(irq));
  srw_lcu_model srw_lcu_model_i (.clk(clk_sys), .press(press), .oe_n(oe_n),
    .master_reset_in_n(mres_n), .shared_n(sh_n));
  task automatic finish_test();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (ack === 1'b1) break;
    end
    cyc <= 1'b0; stb <= 1'b0;
    if (k == 20) begin miscompares++; finish_test(); end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // read data compared against the oldest note
  always @(posedge clk_sys) if (ack === 1'b1 && we === 1'b0) begin
    rexp = expq.pop_front();
    `CHK(dat_o, rexp)
  end
  initial begin clk_sys = 1'b0; forever #10 clk_sys = ~clk_sys; end
  initial begin
    reset = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h0; sel = 4'hf; wdat = 32'h0;
    press = 1'b0; low = 1'b0; s5 = 1'b1; s33 = 1'b1; lamp_n = 1'b1;
    void'($urandom(32'hc16c));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h0000_0006);
    rd(ADDR_CTRL, 32'h0000_0002);
    `CHK(sho, 1'b0)
    @(negedge clk_sys) `CHK(hl, 1'b1)
    r = $urandom & 32'h0000_000f;
    wb(1'b1, ADDR_IRQ_EN, r);
    rd(ADDR_IRQ_EN, r);
    wb(1'b1, 8'h3c, 32'hffff_ffff);
    rd(8'h3c, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h0000_0004);
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys) {lamp_n, s5, s33} <= i[2:0];
      repeat (2) @(negedge clk_sys);
      `CHK(pg_n, !(s5 && s33))
      `CHK(pg_led, !lamp_n || (s5 && s33))
      `CHK(hl, !lamp_n)
    end
    wb(1'b1, ADDR_IRQ_EN, 32'h0);
    wb(1'b1, ADDR_IRQ_CLR, 32'h0000_000f);
    @(posedge clk_sys) press <= 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK({cpu_n, cs_n, per, oe_n}, 4'b0011)
    @(posedge clk_sys) press <= 1'b0;
    `WAITF(cpu_n === 1'b1)
    `CHK(irq, 1'b0)
    rd(ADDR_IRQ_STAT, 32'h0000_0002);
    wb(1'b1, ADDR_IRQ_EN, 32'h0000_0002);
    @(negedge clk_sys) `CHK(irq, 1'b1)
    wb(1'b1, ADDR_IRQ_CLR, 32'h0000_0002);
    @(negedge clk_sys) `CHK(irq, 1'b0)
    wb(1'b1, ADDR_CTRL, 32'h0000_0005);
    repeat (3) begin
      repeat (LIM - 100) @(posedge clk_sys);
      wb(1'b1, ADDR_CTRL, 32'h0000_0005);
    end
    @(negedge clk_sys) `CHK(cpu_n, 1'b1)
    repeat (LIM - 20) @(negedge clk_sys);
    `CHK(cpu_n, 1'b1)
    `WAITF(cpu_n === 1'b0)
    `CHK(k < 40, 1'b1)
    repeat (2) @(negedge clk_sys);
    `CHK({oe_n, sh_n}, 2'b00)
    `WAITF(oe_n === 1'b1)
    `CHK(k < 40, 1'b1)
    `WAITF(cpu_n === 1'b1)
    rd(ADDR_CTRL, 32'h0);
    @(posedge clk_sys) low <= 1'b1;
    repeat (2) @(negedge clk_sys);
    `CHK(cpu_n, 1'b0)
    @(posedge clk_sys) low <= 1'b0;
    `WAITF(cpu_n === 1'b1)
    finish_test();
  end
endmodule // srw_ctrl_tb
